// ### logic/vosc_pkg.sv
// Package: register map, field layout, mode codes and carrier types of the video output status block
package vosc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets (low address byte only is decoded)
    localparam logic [7:0] STATUS_OFFSET = 8'h00;
    localparam logic [7:0] CONTROL_OFFSET = 8'h04;
    localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h08;
    localparam logic [7:0] IRQ_CLEAR_OFFSET = 8'h0c;
    localparam int ADDR_DECODE_WIDTH = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Control register layout and reset value
    localparam logic [31:0] CONTROL_RESET = 32'h32400000;
    localparam logic [31:0] CONTROL_STORE_MASK = 32'h3240001f;
    localparam int CTL_MODE_LSB = 0;
    localparam int CTL_MODE_WIDTH = 4;
    localparam int CTL_ENABLE_BIT = 4;
    localparam int CTL_FIRST_ACK_BIT = 5;
    localparam int CTL_SECOND_ACK_BIT = 6;
    localparam int CTL_PLL_T_BIT = 22;
    localparam int CTL_PLL_S_BIT = 25;
    localparam int CTL_CLOCK_SELECT_LSB = 28;

    ////////////////////////////////////////////////////////////////////////////
    // Status register layout; enable and clear registers share the low bits
    localparam int STAT_FIRST_EMPTY_BIT = 0;
    localparam int STAT_SECOND_EMPTY_BIT = 1;
    localparam int STAT_UNDERRUN_BIT = 2;
    localparam int STAT_UNIT_ID_BIT = 4;
    localparam int STAT_BANDWIDTH_BIT = 5;
    localparam int STAT_PIXEL_LSB = 8;
    localparam int STAT_LINE_LSB = 20;
    localparam int COUNT_WIDTH = 12;
    localparam int BYTE_COUNT_WIDTH = 24;

    // Sticky flag indices inside the flag vector
    localparam int FLAG_COUNT = 4;
    localparam int FLAG_FIRST_EMPTY = 0;
    localparam int FLAG_SECOND_EMPTY = 1;
    localparam int FLAG_UNDERRUN = 2;
    localparam int FLAG_BANDWIDTH = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Operating mode codes; codes below 8 other than 3 and 7 are video refresh
    localparam logic [3:0] MODE_DATA_STREAM = 4'h8;
    localparam logic [3:0] MODE_MESSAGE = 4'h9;
    localparam logic [3:0] MODE_RESERVED_A = 4'h3;
    localparam logic [3:0] MODE_RESERVED_B = 4'h7;

    // Bus slave phases, one-hot
    typedef enum logic [3:0] {
        BUS_IDLE = 4'b0001,
        BUS_WRITE = 4'b0010,
        BUS_READ_WAIT = 4'b0100,
        BUS_READ_DONE = 4'b1000
    } vosc_bus_state_t;

    // Status and events coming from the streaming engine
    typedef struct packed {
        logic [COUNT_WIDTH-1:0] lineCount;
        logic [COUNT_WIDTH-1:0] pixelCount;
        logic [BYTE_COUNT_WIDTH-1:0] sizeCount;
        logic overlapDone;
        logic activeVideoStart;
        logic [1:0] bufferDone;
        logic messageDone;
        logic memoryLate;
    } vosc_engine_status_t;

    // Controls handed to the streaming engine
    typedef struct packed {
        logic [3:0] mode;
        logic enable;
        logic [1:0] clockSelect;
        logic pllS;
        logic pllT;
        logic [1:0] bufferHold;
        logic [1:0] bufferAck;
        logic reusePointers;
    } vosc_engine_control_t;

endpackage : vosc_pkg

// ### logic/vosc_sticky_flag.sv
// Module: one sticky event flag, set by hardware, cleared by software
module vosc_sticky_flag (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic setEvent,
    input wire logic clearEvent,
    output logic flag
);

    // Set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            flag <= 1'b0;
        end else if (ce) begin
            if (setEvent) begin
                flag <= 1'b1;
            end else if (clearEvent) begin
                flag <= 1'b0;
            end
        end
    end

endmodule : vosc_sticky_flag

// ### logic/vosc_video_output_status_control.sv
// Module: status and control registers of the video output unit, AHB-Lite slave
//
// Functional notes
// - Status register is read only; writes never change its fields.
// - Status bit 4 always reads one, whatever the bandwidth error flag.
// - Hardware reset loads control with 0x32400000.
// - Control selects mode, sets clock and PLL bits, clears empty flags, starts operation.
// - Line field mirrors line counter; data modes give a 24-bit byte count.
// - Low two byte-count bits are unreliable during transfers; upper 22 valid.
// - Pixel field reports the index of the most recently output pixel.
// - Video refresh uses first buffer only; empty set after overlap area.
// - First buffer still empty at next active video start sets underrun.
// - Data streaming sets each buffer's empty flag; transfer stops while set.
// - Message mode sets first buffer empty when the message is sent.
// - Each empty flag interrupts when enabled, once per buffer completion.
// - A memory read answered too late sets the bandwidth error flag.
// - Writing one to first buffer acknowledge clears first buffer empty.
// - On underrun the transfer continues with the previous address pointers.
//
// Chosen here: the AHB-Lite interface to the registers and the address map.
module vosc_video_output_status_control
    import vosc_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire vosc_engine_status_t engineStatus,
    output vosc_engine_control_t engineControl,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    vosc_bus_state_t busState;
    logic [ADDR_DECODE_WIDTH-1:0] addrLatch;
    logic addrAccept;
    logic writeStrobe;
    logic writeControl;
    logic writeIrqEnable;
    logic writeIrqClear;
    logic [31:0] control;
    logic [FLAG_COUNT-1:0] irqEnable;
    logic [FLAG_COUNT-1:0] flags;
    logic [FLAG_COUNT-1:0] setFlags;
    logic [FLAG_COUNT-1:0] clearFlags;
    logic [COUNT_WIDTH-1:0] currentLineIndex;
    logic [COUNT_WIDTH-1:0] currentPixelIndex;
    logic [31:0] statusWord;
    logic [31:0] readValue;
    logic [3:0] mode;
    logic unitEnable;
    logic videoMode;
    logic dataMode;
    logic messageMode;
    logic firstAck;
    logic secondAck;
    logic videoUnderrun;
    logic dataUnderrun;
    logic underrunEvent;

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave

    // A transfer is taken only when selected, NONSEQ/SEQ and the bus is ready
    assign addrAccept = hsel && htrans[1] && hready;

    // Phase tracking; reads take one wait state so a write just before is seen
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            busState <= BUS_IDLE;
            addrLatch <= '0;
            hreadyout <= 1'b1;
        end else if (ce) begin
            unique case (busState)
                BUS_IDLE, BUS_WRITE, BUS_READ_DONE: begin
                    if (addrAccept) begin
                        addrLatch <= haddr[ADDR_DECODE_WIDTH-1:0];
                        if (hwrite) begin
                            busState <= BUS_WRITE;
                            hreadyout <= 1'b1;
                        end else begin
                            busState <= BUS_READ_WAIT;
                            hreadyout <= 1'b0;
                        end
                    end else begin
                        busState <= BUS_IDLE;
                        hreadyout <= 1'b1;
                    end
                end
                BUS_READ_WAIT: begin
                    busState <= BUS_READ_DONE;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

    // Response is always OKAY; unmapped reads return zero
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            hresp <= 1'b0;
        end else if (ce) begin
            hresp <= 1'b0;
        end
    end

    // Read data is loaded during the wait state and held until the next read
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            hrdata <= '0;
        end else if (ce && busState == BUS_READ_WAIT) begin
            hrdata <= readValue;
        end
    end

    // Write decode; hwdata stands in the data phase, only whole words are used
    assign writeStrobe = (busState == BUS_WRITE);
    assign writeControl = writeStrobe && (addrLatch == CONTROL_OFFSET);
    assign writeIrqEnable = writeStrobe && (addrLatch == IRQ_ENABLE_OFFSET);
    assign writeIrqClear = writeStrobe && (addrLatch == IRQ_CLEAR_OFFSET);

    ////////////////////////////////////////////////////////////////////////////
    // Control register

    // Only defined bits are stored, so undefined bits always read back zero
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            control <= CONTROL_RESET;
        end else if (ce && writeControl) begin
            control <= hwdata & CONTROL_STORE_MASK;
        end
    end

    // Acknowledge bits act on the write itself and are never stored
    assign firstAck = writeControl && hwdata[CTL_FIRST_ACK_BIT];
    assign secondAck = writeControl && hwdata[CTL_SECOND_ACK_BIT];

    // Mode decode; reserved codes raise no buffer events at all
    assign mode = control[CTL_MODE_LSB +: CTL_MODE_WIDTH];
    assign unitEnable = control[CTL_ENABLE_BIT];
    assign videoMode = !mode[3] && (mode != MODE_RESERVED_A) && (mode != MODE_RESERVED_B);
    assign dataMode = (mode == MODE_DATA_STREAM);
    assign messageMode = (mode == MODE_MESSAGE);

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt enable register

    // Same layout as the status event bits
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            irqEnable <= '0;
        end else if (ce && writeIrqEnable) begin
            irqEnable[FLAG_FIRST_EMPTY] <= hwdata[STAT_FIRST_EMPTY_BIT];
            irqEnable[FLAG_SECOND_EMPTY] <= hwdata[STAT_SECOND_EMPTY_BIT];
            irqEnable[FLAG_UNDERRUN] <= hwdata[STAT_UNDERRUN_BIT];
            irqEnable[FLAG_BANDWIDTH] <= hwdata[STAT_BANDWIDTH_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event detection

    // Video underrun: next field starts while the first buffer is still empty;
    // an acknowledge in that very cycle counts as in time
    assign videoUnderrun = unitEnable && videoMode && engineStatus.activeVideoStart
        && flags[FLAG_FIRST_EMPTY] && !firstAck;

    // Data underrun: a buffer finishes while the other one was never refilled
    assign dataUnderrun = unitEnable && dataMode
        && ((engineStatus.bufferDone[0] && flags[FLAG_SECOND_EMPTY] && !secondAck)
        || (engineStatus.bufferDone[1] && flags[FLAG_FIRST_EMPTY] && !firstAck));

    assign underrunEvent = videoUnderrun || dataUnderrun;

    // Set terms for each sticky flag
    always_comb begin
        setFlags = '0;
        if (unitEnable) begin
            // Video refresh only ever uses the first buffer
            if (videoMode && engineStatus.overlapDone) begin
                setFlags[FLAG_FIRST_EMPTY] = 1'b1;
            end
            if (dataMode) begin
                setFlags[FLAG_FIRST_EMPTY] = engineStatus.bufferDone[0];
                setFlags[FLAG_SECOND_EMPTY] = engineStatus.bufferDone[1];
            end
            if (messageMode && engineStatus.messageDone) begin
                setFlags[FLAG_FIRST_EMPTY] = 1'b1;
            end
            // Late memory answers count in every transfer mode
            if ((videoMode || dataMode || messageMode) && engineStatus.memoryLate) begin
                setFlags[FLAG_BANDWIDTH] = 1'b1;
            end
        end
        setFlags[FLAG_UNDERRUN] = underrunEvent;
    end

    // Clear terms: empty flags only by acknowledge, errors by the clear register
    always_comb begin
        clearFlags = '0;
        clearFlags[FLAG_FIRST_EMPTY] = firstAck;
        clearFlags[FLAG_SECOND_EMPTY] = secondAck;
        clearFlags[FLAG_UNDERRUN] = writeIrqClear && hwdata[STAT_UNDERRUN_BIT];
        clearFlags[FLAG_BANDWIDTH] = writeIrqClear && hwdata[STAT_BANDWIDTH_BIT];
    end

    // One sticky cell per flag, set wins over clear
    for (genvar i = 0; i < FLAG_COUNT; i++) begin : g_flag
        vosc_sticky_flag u_flag (
            .mclk(mclk),
            .rstn(rstn),
            .ce(ce),
            .setEvent(setFlags[i]),
            .clearEvent(clearFlags[i]),
            .flag(flags[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Position and byte counters

    // Captured every cycle; in data modes the two fields form one byte counter.
    // The low two bits follow the engine as is, so mid-transfer they may be stale.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            currentLineIndex <= '0;
            currentPixelIndex <= '0;
        end else if (ce) begin
            if (dataMode || messageMode) begin
                currentLineIndex <= engineStatus.sizeCount[BYTE_COUNT_WIDTH-1:COUNT_WIDTH];
                currentPixelIndex <= engineStatus.sizeCount[COUNT_WIDTH-1:0];
            end else begin
                currentLineIndex <= engineStatus.lineCount;
                currentPixelIndex <= engineStatus.pixelCount;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read multiplexer

    // Status is assembled from live state only; nothing here is writable
    always_comb begin
        statusWord = '0;
        statusWord[STAT_FIRST_EMPTY_BIT] = flags[FLAG_FIRST_EMPTY];
        statusWord[STAT_SECOND_EMPTY_BIT] = flags[FLAG_SECOND_EMPTY];
        statusWord[STAT_UNDERRUN_BIT] = flags[FLAG_UNDERRUN];
        statusWord[STAT_UNIT_ID_BIT] = 1'b1;
        statusWord[STAT_BANDWIDTH_BIT] = flags[FLAG_BANDWIDTH];
        statusWord[STAT_PIXEL_LSB +: COUNT_WIDTH] = currentPixelIndex;
        statusWord[STAT_LINE_LSB +: COUNT_WIDTH] = currentLineIndex;
    end

    // Enable register reads back; the clear register reads as zero
    always_comb begin
        readValue = '0;
        unique case (addrLatch)
            STATUS_OFFSET: readValue = statusWord;
            CONTROL_OFFSET: readValue = control;
            IRQ_ENABLE_OFFSET: begin
                readValue[STAT_FIRST_EMPTY_BIT] = irqEnable[FLAG_FIRST_EMPTY];
                readValue[STAT_SECOND_EMPTY_BIT] = irqEnable[FLAG_SECOND_EMPTY];
                readValue[STAT_UNDERRUN_BIT] = irqEnable[FLAG_UNDERRUN];
                readValue[STAT_BANDWIDTH_BIT] = irqEnable[FLAG_BANDWIDTH];
            end
            default: readValue = '0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt output

    // Level output, high while any enabled flag stands; a flag rising while another is set gives no new request
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(flags & irqEnable);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Engine controls

    // Registered so every engine control comes straight from a flip-flop.
    // One process owns the whole struct, so no field has two drivers.
    // A streaming buffer is held while its empty flag stands, including the cycle it is set
    // unless an acknowledge met the set event, so no byte leaves an exhausted buffer
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            engineControl <= '0;
        end else if (ce) begin
            engineControl.mode <= mode;
            engineControl.enable <= unitEnable;
            engineControl.clockSelect <= control[CTL_CLOCK_SELECT_LSB +: 2];
            engineControl.pllS <= control[CTL_PLL_S_BIT];
            engineControl.pllT <= control[CTL_PLL_T_BIT];
            engineControl.bufferAck <= {secondAck, firstAck};
            engineControl.reusePointers <= underrunEvent;
            if (dataMode) begin
                engineControl.bufferHold[0] <= (flags[FLAG_FIRST_EMPTY] || setFlags[FLAG_FIRST_EMPTY])
                    && !firstAck;
                engineControl.bufferHold[1] <= (flags[FLAG_SECOND_EMPTY] || setFlags[FLAG_SECOND_EMPTY])
                    && !secondAck;
            end else begin
                engineControl.bufferHold <= '0;
            end
        end
    end

endmodule : vosc_video_output_status_control

// ### test/vosc_checker.sv
// Checker: bus, flag and engine-control timing of the status block
module vosc_checker
    import vosc_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire vosc_engine_status_t engineStatus,
    input wire vosc_engine_control_t engineControl,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ctlData;
    logic ctlWritten;
    wire taken = hsel && htrans[1] && hready && ce;
    wire ctlAddr = haddr[7:0] == CONTROL_OFFSET;
    wire cause = (|engineStatus[5:0]) || (taken && hwrite);

    // Control write data phase, and whether any control write has landed since reset
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ctlData <= 1'b0;
            ctlWritten <= 1'b0;
        end else begin
            ctlData <= taken && hwrite && ctlAddr;
            ctlWritten <= ctlWritten || ctlData;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////////////
    // Multi-step bus sequences
    sequence statusRead;
        taken && !hwrite && haddr[7:0] == STATUS_OFFSET ##1 !hreadyout;
    endsequence
    sequence ackWrite;
        taken && hwrite && ctlAddr ##1 hwdata[CTL_FIRST_ACK_BIT];
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    unit_bit_a: assert property (statusRead |=> hrdata[STAT_UNIT_ID_BIT])
        else $error("unit bit read as zero");
    reset_value_a: assert property (!ctlWritten && !ctlData && $past(rstn) |->
        engineControl.clockSelect == 2'b11 && engineControl.pllS && engineControl.pllT && engineControl.mode == 4'h0)
        else $error("control outputs differ from reset value");
    ack_pulse_a: assert property (ackWrite |-> ##[0:1] engineControl.bufferAck[0])
        else $error("acknowledge write gave no ack pulse");
    reuse_cause_a: assert property (engineControl.reusePointers |->
        $past(engineStatus.activeVideoStart || engineStatus.bufferDone != 2'b00))
        else $error("pointer reuse without underrun cause");
    hold_cause_a: assert property ($rose(engineControl.bufferHold[0]) |-> $past(engineStatus.bufferDone[0]))
        else $error("buffer hold rose without buffer done");
    hold_mode_a: assert property (engineControl.bufferHold != 2'b00 |-> engineControl.mode == MODE_DATA_STREAM)
        else $error("buffer hold outside data mode");
    irq_cause_a: assert property ($rose(irq) |-> $past(cause, 2) || $past(cause, 3))
        else $error("interrupt rose without cause");
    mode_change_a: assert property ($changed(engineControl.mode) |-> $past(ctlData) || $past(ctlData, 2))
        else $error("mode changed without control write");
endmodule : vosc_checker

bind vosc_video_output_status_control vosc_checker u_chk (.mclk, .rstn, .ce, .hsel, .haddr, .htrans, .hwrite,
    .hready, .hwdata, .hrdata, .hreadyout, .engineStatus, .engineControl, .irq);

// ### test/vosc_engine_model.sv
// Model: streaming engine stand-in driving counter levels and one-cycle event pulses
module vosc_engine_model
    import vosc_pkg::*;
(
    input wire logic mclk,
    input wire vosc_engine_control_t engineControl,
    output vosc_engine_status_t engineStatus
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] lineCnt;
    logic [11:0] pixelCnt;
    logic [23:0] sizeCnt;
    logic [5:0] evt;

    // Counters are levels; events last exactly one clock
    initial begin
        lineCnt = 12'h0;
        pixelCnt = 12'h0;
        sizeCnt = 24'h0;
        evt = 6'h0;
    end
    assign engineStatus = {lineCnt, pixelCnt, sizeCnt, evt};

    task automatic setCount(input logic [11:0] l, input logic [11:0] p, input logic [23:0] s);
        @(posedge mclk);
        lineCnt <= l;
        pixelCnt <= p;
        sizeCnt <= s;
    endtask : setCount

    // Event bits: overlap, video start, done 2, done 1, message, late
    task automatic pulse(input logic [5:0] e);
        @(posedge mclk);
        evt <= e;
        @(posedge mclk);
        evt <= 6'h0;
    endtask : pulse
endmodule : vosc_engine_model

// ### test/vosc_video_output_status_control_test.sv
// Testbench: register access, flag and interrupt scenarios of the status block
module vosc_video_output_status_control_test
    import vosc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rstn, ce, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    vosc_engine_status_t engineStatus;
    vosc_engine_control_t engineControl;
    int n_fail, checks;

    vosc_video_output_status_control dut (.mclk(mclk), .rstn(rstn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .engineStatus(engineStatus), .engineControl(engineControl), .irq(irq));
    vosc_engine_model em (.mclk(mclk), .engineControl(engineControl), .engineStatus(engineStatus));

    // 40 MHz clock
    always #12.5 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (n_fail == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Bounded wait for hready sampled high at an edge
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            n_fail++;
            end_sim();
        end
    endtask : wait_ready

    // One single AHB-Lite word transfer; read data lands in rdata
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        hsize <= 3'b010;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hsize <= 3'b000;
        hwdata <= d;
        wait_ready();
        rdata = hrdata;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask : rdchk

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rdchk(CONTROL_OFFSET, 32'h32400000);
        rdchk(STATUS_OFFSET, 32'h00000010);
        rdchk(IRQ_ENABLE_OFFSET, 32'h0);
        chk({30'h0, hresp, irq}, 32'h0);
        chk({24'h0, engineControl.clockSelect, engineControl.pllS, engineControl.pllT, engineControl.mode},
            32'h000000f0);
    endtask : t_reset

    task automatic t_fields();
        em.setCount(12'h5a3, 12'h0c7, 24'h0);
        wr(CONTROL_OFFSET, 32'h32400010);
        rdchk(STATUS_OFFSET, 32'h5a30c710);
        wr(STATUS_OFFSET, 32'h0000003f);
        rdchk(STATUS_OFFSET, 32'h5a30c710);
        rdchk(8'h10, 32'h0);
        rdchk(IRQ_CLEAR_OFFSET, 32'h0);
        em.setCount(12'h0, 12'h0, 24'h0);
    endtask : t_fields

    // Video refresh: overlap done, masked then enabled irq, underrun, ack
    task automatic t_video();
        em.pulse(6'h20);
        rdchk(STATUS_OFFSET, 32'h11);
        chk({31'h0, irq}, 32'h0);
        wr(IRQ_ENABLE_OFFSET, 32'h27);
        rdchk(IRQ_ENABLE_OFFSET, 32'h27);
        chk({31'h0, irq}, 32'h1);
        rdchk(STATUS_OFFSET, 32'h11);
        em.pulse(6'h10);
        rdchk(STATUS_OFFSET, 32'h15);
        wr(CONTROL_OFFSET, 32'h32400030);
        rdchk(CONTROL_OFFSET, 32'h32400010);
        rdchk(STATUS_OFFSET, 32'h14);
        wr(IRQ_CLEAR_OFFSET, 32'h4);
        rdchk(STATUS_OFFSET, 32'h10);
        chk({31'h0, irq}, 32'h0);
    endtask : t_video

    // Data streaming: byte count, both buffers done, underrun, double ack
    task automatic t_data();
        wr(CONTROL_OFFSET, 32'h32400018);
        em.setCount(12'h123, 12'h457, 24'h123457);
        xfer(1'b0, STATUS_OFFSET, 32'h0);
        chk({10'h0, rdata[31:10]}, 32'h123457 >> 2);
        em.setCount(12'h0, 12'h0, 24'h0);
        em.pulse(6'h04);
        rdchk(STATUS_OFFSET, 32'h11);
        em.pulse(6'h08);
        rdchk(STATUS_OFFSET, 32'h17);
        chk({30'h0, engineControl.bufferHold}, 32'h3);
        chk({31'h0, irq}, 32'h1);
        wr(CONTROL_OFFSET, 32'h32400078);
        wr(IRQ_CLEAR_OFFSET, 32'h4);
        rdchk(STATUS_OFFSET, 32'h10);
    endtask : t_data

    // Message passing, bandwidth error, then error clear and first buffer acknowledge
    task automatic t_message();
        wr(CONTROL_OFFSET, 32'h32400019);
        em.pulse(6'h02);
        rdchk(STATUS_OFFSET, 32'h11);
        em.pulse(6'h01);
        rdchk(STATUS_OFFSET, 32'h31);
        wr(IRQ_CLEAR_OFFSET, 32'h20);
        wr(CONTROL_OFFSET, 32'h32400039);
        rdchk(STATUS_OFFSET, 32'h10);
    endtask : t_message

    // Reserved mode and disabled unit ignore events
    task automatic t_ignored();
        wr(CONTROL_OFFSET, 32'h32400013);
        em.pulse(6'h20);
        em.pulse(6'h01);
        rdchk(STATUS_OFFSET, 32'h10);
        wr(CONTROL_OFFSET, 32'h32400000);
        em.pulse(6'h20);
        rdchk(STATUS_OFFSET, 32'h10);
    endtask : t_ignored

    // Clock enable low freezes event capture; a mid-run reset clears the flags
    task automatic t_freeze();
        wr(CONTROL_OFFSET, 32'h32400010);
        @(posedge mclk);
        ce <= 1'b0;
        em.pulse(6'h20);
        @(posedge mclk);
        ce <= 1'b1;
        rdchk(STATUS_OFFSET, 32'h10);
        em.pulse(6'h20);
        rdchk(STATUS_OFFSET, 32'h11);
        chk({31'h0, irq}, 32'h1);
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        t_reset();
    endtask : t_freeze

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        rstn = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        n_fail = 0;
        checks = 0;
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        t_reset();
        t_fields();
        t_video();
        t_data();
        t_message();
        t_ignored();
        t_freeze();
        end_sim();
    end
endmodule : vosc_video_output_status_control_test
